// file: src/ibrd_map.vh
`ifndef IBRD_MAP_VH
`define IBRD_MAP_VH
// Clock rate and derived periods
`define IBRD_CLK_HZ          10000000
`define IBRD_CLK_PERIOD_NS   100
// Signature pattern, first pulse in bit 3
`define IBRD_SIG_PATTERN     4'h5
`define IBRD_SIG_PULSES      3'h4
// Reset recovery time and its cycle count
`define IBRD_RECOVERY_NS     100000
`define IBRD_RECOVERY_CYC    ((`IBRD_RECOVERY_NS + `IBRD_CLK_PERIOD_NS - 1) / `IBRD_CLK_PERIOD_NS)
// Internal reset pulse length in cycles
`define IBRD_RESET_CYC       8
`endif

// file: src/ibrd_in_band_reset_detector.v
// Behaviour
// RQ1: Master keeps serial clock still while select is low during signature.
// RQ2: Master sets data line zero after select falls, holds it past rise.
// RQ3: Master gives four pulses, data low first, alternating after.
// RQ4: Device samples data line zero on each select rising edge.
// RQ5: Internal reset starts after fourth pulse only if bits read low-high-low-high.
// RQ6: Device never drives data line zero before first clock edge of select; code drives it for one cycle when select falls after a clocked period.
// RQ7: Select falling during signature wakes a powered-down device.
// RQ8: Signature is recognised in every mode and state.
// RQ9: Select activity and commands are ignored while reset runs.
// RQ10: Normal command handling resumes after reset and recovery time.
// RQ11: Master holds select low at least 500 ns per pulse.
// RQ12: Master holds select high at least 500 ns between pulses.
// RQ13: Master uses signature only for recovery, not at power-on.
// RQ14: Clock edge with select low abandons partial signature; ordinary command.
`include "ibrd_map.vh"
module ibrd_in_band_reset_detector
#(
	parameter RECOVERY_CYC = `IBRD_RECOVERY_CYC
)
(
	// Clock and reset
	input  wire       clk,
	input  wire       rstn,
	// Pins from the bus master
	input  wire       select_n,
	input  wire       serial_clk,
	input  wire       data_line_zero_in,
	// Core side
	input  wire       core_powered_down,
	input  wire       core_out_en_req,
	input  wire       core_out_data,
	// Pin drive
	output reg        data_line_zero_out,
	output reg        data_line_zero_oe,
	// Status to the core
	output reg        core_reset,
	output reg        core_wake,
	output reg        bus_enable
);

	localparam ST_IDLE    = 2'h0;
	localparam ST_RESET   = 2'h1;
	localparam ST_RECOVER = 2'h2;

	// Two-stage synchronisers for the three pins
	reg [2:0] sync1;
	reg [2:0] sync2;
	reg [2:0] prev;
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
			prev  <= 3'h7;
		end
		else
		begin
			sync1 <= {select_n, serial_clk, data_line_zero_in};
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	wire sel_n   = sync2[2];
	wire sclk    = sync2[1];
	wire dq0     = sync2[0];
	wire sel_rise = sel_n & ~prev[2];
	wire sel_fall = ~sel_n & prev[2];
	wire clk_edge = sclk ^ prev[1];

	// Sequencer state and signature collection
	reg  [1:0]  state;
	reg  [2:0]  pulses;
	reg  [3:0]  bits;
	reg         clocked;
	reg  [31:0] count;

	// Next values, worked out combinationally each cycle
	reg  [1:0]  next_state;
	reg  [2:0]  next_pulses;
	reg  [3:0]  next_bits;
	reg         next_clocked;
	reg  [31:0] next_count;
	reg         next_core_reset;
	reg         next_core_wake;
	reg         next_bus_enable;

	// Last pulse index and counter end points
	localparam [2:0]  LAST_PULSE   = `IBRD_SIG_PULSES - 3'h1;
	localparam [31:0] RESET_LAST   = `IBRD_RESET_CYC - 1;
	localparam [31:0] RECOVER_LAST = RECOVERY_CYC - 1;

	// Qualified events; a clocked select is a command, never a pulse
	wire [3:0]  shifted    = {bits[2:0], dq0}; // First pulse ends in bit 3
	wire        pulse_done = sel_rise & ~clocked & ~clk_edge;
	wire        sig_match  = (shifted == `IBRD_SIG_PATTERN);

	// Next-state logic; not gated by core state so a stuck core still recovers
	always @* // RQ8
	begin
		next_state      = state;
		next_pulses     = pulses;
		next_bits       = bits;
		next_clocked    = clocked;
		next_count      = count;
		next_core_reset = core_reset;
		next_core_wake  = 1'b0;
		next_bus_enable = bus_enable;

		case (state)
		ST_IDLE:
		begin
			if (sel_fall)
			begin
				next_clocked = 1'b0;
				if (core_powered_down)
					next_core_wake = 1'b1; // RQ7
			end

			if (!sel_n && clk_edge)
			begin
				next_clocked = 1'b1;
				next_pulses  = 3'h0; // RQ14
				next_bits    = 4'h0;
			end

			if (pulse_done)
			begin
				next_bits   = shifted; // RQ4
				next_pulses = pulses + 3'h1;
				if (pulses == LAST_PULSE)
				begin
					next_pulses = 3'h0;
					next_bits   = 4'h0;
					if (sig_match)
					begin
						next_state      = ST_RESET; // RQ5
						next_core_reset = 1'b1;
						next_bus_enable = 1'b0; // RQ9
						next_count      = 32'h0;
					end
				end
			end
		end

		ST_RESET:
		begin
			next_count = count + 32'h1; // RQ9
			if (count == RESET_LAST)
			begin
				next_core_reset = 1'b0;
				next_count      = 32'h0;
				next_state      = ST_RECOVER;
			end
		end

		ST_RECOVER:
		begin
			next_count = count + 32'h1;
			if (count == RECOVER_LAST)
			begin
				next_bus_enable = 1'b1; // RQ10
				next_state      = ST_IDLE;
				next_clocked    = 1'b0;
			end
		end

		default:
			next_state = ST_IDLE;
		endcase
	end

	// State registers; synchronous reset to the idle, bus-enabled state
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			state      <= ST_IDLE;
			pulses     <= 3'h0;
			bits       <= 4'h0;
			clocked    <= 1'b0;
			count      <= 32'h0;
			core_reset <= 1'b0;
			core_wake  <= 1'b0;
			bus_enable <= 1'b1;
		end
		else
		begin
			state      <= next_state;
			pulses     <= next_pulses;
			bits       <= next_bits;
			clocked    <= next_clocked;
			count      <= next_count;
			core_reset <= next_core_reset;
			core_wake  <= next_core_wake;
			bus_enable <= next_bus_enable;
		end
	end

	// Output drive after a clock edge in this select period, and for one cycle as select falls while clocked still marks the last period
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			data_line_zero_oe  <= 1'b0;
			data_line_zero_out <= 1'b0;
		end
		else
		begin
			data_line_zero_oe  <= bus_enable & ~sel_n & clocked & core_out_en_req; // RQ6
			data_line_zero_out <= core_out_data;
		end
	end

endmodule

// file: dv/ibrd_asserts.sv
module ibrd_chk(input wire clk, rstn, select_n, serial_clk, data_line_zero_in,
	core_powered_down, core_out_en_req, core_out_data, data_line_zero_out,
	data_line_zero_oe, core_reset, core_wake, bus_enable);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_reset_len: assert property ($rose(core_reset) |-> core_reset[*8] ##1 !core_reset)
		else $error("reset length");
	a_sel_cause: assert property ($rose(core_reset) |-> $past(select_n, 2))
		else $error("reset without select rise");
	a_bus_off: assert property ($rose(core_reset) |-> $fell(bus_enable))
		else $error("bus stays on");
	a_bus_low: assert property ($rose(core_reset) |=> !bus_enable[*8])
		else $error("bus back early");
	a_bus_back: assert property ($fell(core_reset) |-> ##[1:1000] bus_enable)
		else $error("bus never back");
	a_oe_quiet: assert property (core_reset && $past(core_reset) |-> !data_line_zero_oe)
		else $error("drive during reset");
	a_wake_pulse: assert property (core_wake |=> !core_wake)
		else $error("wake too long");
	a_wake_cause: assert property (core_wake |-> $past(core_powered_down))
		else $error("wake while awake");
endmodule
bind ibrd_in_band_reset_detector ibrd_chk u_chk(.*);

// file: dv/ibrd_host.sv
module ibrd_host(input wire clk, output logic select_n = 1, serial_clk = 0, dq = 1);
	timeunit 1ns;
	timeprecision 1ns;
	// One signature; ck puts a clock edge in each low period
	task automatic send(input logic [3:0] pat, input logic ck);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk) #1 select_n = 0;
			repeat (2) @(posedge clk);
			#1 dq = pat[i];
			serial_clk ^= ck;
			repeat (4) @(posedge clk);
			#1 select_n = 1;
			@(posedge clk) #1 dq = ~dq; // Released: no stale level
			repeat (5) @(posedge clk);
		end
	endtask
endmodule

// file: dv/ibrd_in_band_reset_detector_tb.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module ibrd_in_band_reset_detector_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, pd = 0, rr = 0;
	wire sn, sck, dq, oe, out, rst, wk, be;
	int err_count, checks, cyc, nres, nwk, noe;
	ibrd_host h(.clk(clk), .select_n(sn), .serial_clk(sck), .dq(dq));
	ibrd_in_band_reset_detector #(.RECOVERY_CYC(60)) dut(.clk(clk), .rstn(rstn),
		.select_n(sn), .serial_clk(sck), .data_line_zero_in(oe ? out : dq),
		.core_powered_down(pd), .core_out_en_req(1'b1), .core_out_data(1'b0),
		.data_line_zero_out(out), .data_line_zero_oe(oe), .core_reset(rst),
		.core_wake(wk), .bus_enable(be));
	initial forever #50 clk = ~clk;
	// Event counters and hang guard
	always @(posedge clk)
	begin
		rr <= rst;
		nres += (rst === 1 && !rr);
		nwk += (wk === 1);
		noe += (oe === 1);
		if (++cyc > 2000)
		begin
			err_count++;
			wrap_up;
		end
	end
	task wrap_up;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Second signature lands inside reset and recovery and must vanish
	task t_sig;
		pd = 1;
		h.send(4'ha, 0);
		pd = 0;
		h.send(4'ha, 0);
		repeat (80) @(posedge clk);
		`CHK(nres, 1)
		`CHK(nwk, 4)
		`CHK(noe, 0)
		`CHK(be, 1'b1)
	endtask
	task t_bad;
		h.send(4'h5, 0);
		repeat (10) @(posedge clk);
		`CHK(nres, 1)
	endtask
	task t_abn;
		h.send(4'ha, 1);
		repeat (10) @(posedge clk);
		`CHK(nres, 1)
		`CHK(noe > 0, 1'b1)
		h.send(4'ha, 0);
		repeat (80) @(posedge clk);
		`CHK(nres, 2)
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		#1 rstn = 1;
		repeat (5) @(posedge clk);
		t_sig;
		t_bad;
		t_abn;
		wrap_up;
	end
endmodule
